/* bench/interrupt_pending_set_clear_bench.sv */
// Self-checking bench of the pending set/clear register block.
`include "pend_params.svh"

module interrupt_pending_set_clear_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [77:0] irq_req, irq_enable, irq_active, pending, exp_q;
  logic [31:0] masks [3];
  int          miscompares, comparisons, cycles;

  // Device and its source model.
  pend_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
    .irq_enable(irq_enable), .irq_active(irq_active), .pending(pending));
  irq_sources i_src (.hclk(hclk), .irq_req(irq_req),
    .irq_enable(irq_enable), .irq_active(irq_active));

  // Clock and hang guard.
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  // Verdict and end of run.
  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; waits hold all signals until hready is seen.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  function automatic logic [31:0] slice(input int b);
    return 32'(exp_q >> (32 * b)) & masks[b];
  endfunction

  // Both banks and the flag port must agree with the expected flags.
  task automatic verify();
    logic [31:0] rd;
    for (int b = 0; b < 3; b++) begin
      bus(1'b0, 8'h20 + 8'(4 * b), 32'h0, rd);
      check(rd, slice(b));
      bus(1'b0, 8'(4 * b), 32'h0, rd);
      check(rd, slice(b));
      check(32'(pending >> (32 * b)), slice(b));
    end
    check({31'h0, hresp}, 32'h0);
  endtask

  // Set every bit of each set bank; only implemented positions stick.
  task automatic t_map();
    logic [31:0] rd;
    i_src.status({78{1'b1}}, 78'h0);
    for (int b = 0; b < 3; b++) wr(8'(4 * b), 32'hffffffff);
    wr(8'h40, 32'hffffffff);
    exp_q = {masks[2][13:0], masks[1], masks[0]};
    verify();
    bus(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
  endtask

  // Zero writes, blocked clears for active handling, and partial clears.
  task automatic t_clear();
    for (int b = 0; b < 3; b++) wr(8'h20 + 8'(4 * b), 32'h0);
    verify();
    i_src.status({78{1'b1}}, (78'hff << 40) | 78'h2);
    wr(8'h24, 32'hffffffff);
    exp_q[63:32] = masks[1] & 32'h0000ff00;
    // Interrupt 1 is active, so its bit in this clear word is void.
    wr(8'h20, 32'h55555557);
    exp_q[31:0] = exp_q[31:0] & 32'haaaaaaaa;
    verify();
  endtask

  // A disabled interrupt cannot be forced; an enabled one can.
  task automatic t_gate();
    i_src.status(78'h0, 78'h0);
    wr(8'h20, 32'hffffffff);
    exp_q[31:0] = 32'h0;
    wr(8'h00, 32'hffffffff);
    verify();
    i_src.status({78{1'b1}}, 78'h0);
    wr(8'h00, 32'hffffffff);
    exp_q[31:0] = masks[0];
    verify();
  endtask

  // Source requests land in the shared flag; reserved positions stay low.
  task automatic t_source();
    logic [31:0] rd;
    wr(8'h28, 32'hffffffff);
    exp_q[77:64] = 14'h0;
    i_src.request(66, 3);
    i_src.request(11, 1);
    exp_q[66] = 1'b1;
    verify();
    // Clear, then set, interrupt 40 and read it through the other bank.
    wr(8'h24, 32'h00000100);
    exp_q[40] = 1'b0;
    bus(1'b0, 8'h04, 32'h0, rd);
    check(rd, slice(1));
    wr(8'h04, 32'h00000100);
    exp_q[40] = 1'b1;
    bus(1'b0, 8'h24, 32'h0, rd);
    check(rd, slice(1));
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    exp_q = 78'h0;
    masks = '{`PEND_MASK1, `PEND_MASK2, `PEND_MASK3};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    verify();
    t_map();
    t_clear();
    t_gate();
    t_source();
    print_verdict();
  end
endmodule

/* bench/irq_sources.sv */
// Model of the interrupt sources and core status lines.
module irq_sources (
  // Clock.
  input  wire logic        hclk,
  // Request, enable and activity lines.
  output logic      [77:0] irq_req,
  output logic      [77:0] irq_enable,
  output logic      [77:0] irq_active
);
  timeunit 1ns;
  timeprecision 1ps;

  // All lines start quiet.
  initial begin
    irq_req = 78'h0;
    irq_enable = 78'h0;
    irq_active = 78'h0;
  end

  // One-cycle request after a chosen delay, so prompt and slow both occur.
  task automatic request(input int n, input int dly);
    repeat (dly) @(posedge hclk);
    irq_req[n] <= 1'b1;
    @(posedge hclk);
    irq_req[n] <= 1'b0;
  endtask

  // Enable and activity change just after an edge.
  task automatic status(input logic [77:0] en, input logic [77:0] act);
    @(posedge hclk);
    irq_enable <= en;
    irq_active <= act;
  endtask
endmodule

/* hw/pend_next.sv */
// Next-state logic of the pending flags, one cell per interrupt.
`include "pend_params.svh"

module pend_next (
  // Current flags.
  input  wire logic [77:0] flags_q,
  // Bus write in its data phase.
  input  wire logic        wr_en,
  input  wire logic        wr_set,
  input  wire logic [1:0]  wr_bank,
  input  wire logic [31:0] wdata,
  // Interrupt sources and core status.
  input  wire logic [77:0] irq_req,
  input  wire logic [77:0] irq_enable,
  input  wire logic [77:0] irq_active,
  // Next flags.
  output logic      [77:0] flags_d
);

  localparam logic [95:0] IMPL = {`PEND_MASK3, `PEND_MASK2, `PEND_MASK1};

  // One cell per interrupt; a source request wins over a clear write.
  for (genvar i = 0; i < `PEND_NUM_IRQ; i++) begin : g_cell
    localparam logic [1:0] BANK = 2'(i / `PEND_BANK_W);
    localparam int         POS  = i % `PEND_BANK_W;
    logic hit;
    logic set_w;
    logic clr_w;
    assign hit   = wr_en && (wr_bank == BANK) && wdata[POS];
    // Disabled interrupts ignore the set write.
    assign set_w = hit && wr_set && irq_enable[i];
    // Handling already started makes the clear void.
    assign clr_w = hit && !wr_set && !irq_active[i];
    if (IMPL[i]) begin : g_impl
      assign flags_d[i] = irq_req[i] || set_w || (flags_q[i] && !clr_w);
    end else begin : g_resv
      assign flags_d[i] = 1'b0;
    end
  end

endmodule

/* hw/pend_params.svh */
// Constants of the interrupt pending set/clear block.
// Function
// - Clear write of one removes pending state.
// - Clear ignored for interrupt already being handled.
// - Clear write of zero changes nothing.
// - Clear bank reads back current pending flags.
// - Clear bank one maps listed interrupts 0-31.
// - Set bank two bit n is interrupt 32+n.
// - Set bank three bits 2-13 are 66-77.
// - Set write of one pends enabled interrupt.
`ifndef PEND_PARAMS_SVH
`define PEND_PARAMS_SVH

// Register byte offsets within the block's address window.
`define PEND_SET_BANK1_OFS  8'h00
`define PEND_SET_BANK2_OFS  8'h04
`define PEND_SET_BANK3_OFS  8'h08
`define PEND_CLR_BANK1_OFS  8'h20
`define PEND_CLR_BANK2_OFS  8'h24
`define PEND_CLR_BANK3_OFS  8'h28

// Bank indices.
`define PEND_BANK1          2'h0
`define PEND_BANK2          2'h1
`define PEND_BANK3          2'h2

// Implemented bit positions per bank.
`define PEND_MASK1          32'hcffa47ff
`define PEND_MASK2          32'h3d7fdf00
`define PEND_MASK3          32'h00003ffc

// Interrupt count and bank width.
`define PEND_NUM_IRQ        78
`define PEND_BANK_W         32

// Reset values; flags are undefined at reset, cleared here for determinism.
`define PEND_FLAGS_RST      78'h0
`define PEND_RDATA_RST      32'h0

// AHB encodings.
`define PEND_HTRANS_NSEQ_B  1
`define PEND_HRESP_OKAY     1'b0

`endif

/* hw/pend_pkg.sv */
// Types shared by the interrupt pending set/clear block.
package pend_pkg;

  // Whole register state of the bus-facing top module.
  typedef struct packed {
    logic [77:0] flags;
    logic        wr_pend;
    logic        wr_set;
    logic [1:0]  wr_bank;
    logic [31:0] rdata;
    logic        ready;
  } slave_state_t;

endpackage

/* hw/pend_regs.sv */
// AHB-Lite register slave holding the shared interrupt pending flags.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`include "pend_params.svh"

module pend_regs (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt sources and core status.
  input  wire logic [77:0] irq_req,
  input  wire logic [77:0] irq_enable,
  input  wire logic [77:0] irq_active,
  // Pending flags towards the arbiter.
  output logic      [77:0] pending
);

  pend_pkg::slave_state_t s_q;
  pend_pkg::slave_state_t s_d;
  logic [77:0]            flags_nx;
  logic                   acc;
  logic                   hit;
  logic                   is_set;
  logic [1:0]             bank;
  logic [7:0]             ofs;

  // Next flags come from the per-interrupt cells.
  pend_next u_next (
    .flags_q    (s_q.flags),
    .wr_en      (s_q.wr_pend),
    .wr_set     (s_q.wr_set),
    .wr_bank    (s_q.wr_bank),
    .wdata      (hwdata),
    .irq_req    (irq_req),
    .irq_enable (irq_enable),
    .irq_active (irq_active),
    .flags_d    (flags_nx)
  );

  // Address decode; hsize is ignored since only whole words are used.
  assign acc = hsel && htrans[`PEND_HTRANS_NSEQ_B] && hready;
  assign ofs = haddr[7:0];

  always_comb begin
    hit    = 1'b1;
    is_set = 1'b0;
    bank   = `PEND_BANK1;
    unique case (ofs)
      `PEND_SET_BANK1_OFS: begin
        is_set = 1'b1;
      end
      `PEND_SET_BANK2_OFS: begin
        is_set = 1'b1;
        bank   = `PEND_BANK2;
      end
      `PEND_SET_BANK3_OFS: begin
        is_set = 1'b1;
        bank   = `PEND_BANK3;
      end
      `PEND_CLR_BANK1_OFS: bank = `PEND_BANK1;
      `PEND_CLR_BANK2_OFS: bank = `PEND_BANK2;
      `PEND_CLR_BANK3_OFS: bank = `PEND_BANK3;
      default: hit = 1'b0;
    endcase
  end

  // Read data is taken from the next flags, so a write in the previous
  // data phase is already visible; unmapped addresses read as zero.
  always_comb begin
    s_d         = s_q;
    s_d.flags   = flags_nx;
    s_d.ready   = 1'b1;
    s_d.wr_pend = acc && hit && hwrite;
    s_d.wr_set  = is_set;
    s_d.wr_bank = bank;
    if (acc && !hwrite) begin
      s_d.rdata = `PEND_RDATA_RST;
      if (hit) begin
        unique case (bank)
          `PEND_BANK1: s_d.rdata = flags_nx[31:0];
          `PEND_BANK2: s_d.rdata = flags_nx[63:32];
          `PEND_BANK3: s_d.rdata = {18'h0, flags_nx[77:64]};
          default:     s_d.rdata = `PEND_RDATA_RST;
        endcase
      end
    end
  end

  // Single state register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.flags   <= `PEND_FLAGS_RST;
      s_q.wr_pend <= 1'b0;
      s_q.wr_set  <= 1'b0;
      s_q.wr_bank <= `PEND_BANK1;
      s_q.rdata   <= `PEND_RDATA_RST;
      s_q.ready   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops; the response is always OKAY.
  assign hrdata    = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp     = `PEND_HRESP_OKAY;
  assign pending   = s_q.flags;

  // Checks.
  property p_clear_one;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && !s_q.wr_set && s_q.wr_bank == `PEND_BANK1 &&
       hwdata[0] && !irq_active[0] && !irq_req[0]) |=> !pending[0];
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("clear write did not remove pending flag");

  property p_clear_active;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && !s_q.wr_set && s_q.wr_bank == `PEND_BANK1 &&
       hwdata[1] && irq_active[1] && pending[1]) |=> pending[1];
  endproperty
  a_clear_active: assert property (p_clear_active)
    else $error("clear write removed flag of active interrupt");

  property p_clear_zero;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && !s_q.wr_set && s_q.wr_bank == `PEND_BANK1 &&
       !hwdata[2] && pending[2]) |=> pending[2];
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("zero clear write changed pending flag");

  property p_read_back;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && ofs == `PEND_CLR_BANK1_OFS) |=>
        (hrdata == pending[31:0]) && hreadyout;
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("clear bank read differs from pending flags");

  property p_bank1_resv;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && ofs == `PEND_CLR_BANK1_OFS) |=>
        ((hrdata & ~`PEND_MASK1) == 32'h0);
  endproperty
  a_bank1_resv: assert property (p_bank1_resv)
    else $error("reserved bit of bank one reads as one");

  property p_set_bank2;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_set && s_q.wr_bank == `PEND_BANK2 &&
       hwdata[24] && irq_enable[56]) |=> pending[56] && !pending[55];
  endproperty
  a_set_bank2: assert property (p_set_bank2)
    else $error("bank two set did not pend interrupt 56");

  property p_set_bank3;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_set && s_q.wr_bank == `PEND_BANK3 &&
       hwdata[13] && irq_enable[77]) |=> pending[77] && !pending[65];
  endproperty
  a_set_bank3: assert property (p_set_bank3)
    else $error("bank three set did not pend interrupt 77");

  property p_set_disabled;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_set && s_q.wr_bank == `PEND_BANK1 &&
       hwdata[3] && !irq_enable[3] && !pending[3] && !irq_req[3])
        |=> !pending[3];
  endproperty
  a_set_disabled: assert property (p_set_disabled)
    else $error("set write pended a disabled interrupt");

  property p_shared_flag;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_set && s_q.wr_bank == `PEND_BANK2 &&
       hwdata[8] && irq_enable[40]) ##1
      (acc && !hwrite && ofs == `PEND_CLR_BANK2_OFS && !irq_active[40])
        |=> hrdata[8];
  endproperty
  a_shared_flag: assert property (p_shared_flag)
    else $error("set through one bank not seen through the other");

  // Reads of the other two clear banks track the shared flags.
  property p_read_bank2;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && ofs == `PEND_CLR_BANK2_OFS) |=>
        (hrdata == pending[63:32]);
  endproperty
  a_read_bank2: assert property (p_read_bank2)
    else $error("clear bank two read differs from pending flags");

  property p_read_bank3;
    @(posedge hclk) disable iff (!hresetn)
      (acc && !hwrite && ofs == `PEND_CLR_BANK3_OFS) |=>
        (hrdata == {18'h0, pending[77:64]});
  endproperty
  a_read_bank3: assert property (p_read_bank3)
    else $error("clear bank three read differs from pending flags");

  // Reserved positions of banks two and three never hold a flag.
  property p_bank2_resv;
    @(posedge hclk) disable iff (!hresetn)
      (pending[63:32] & ~`PEND_MASK2) == 32'h0;
  endproperty
  a_bank2_resv: assert property (p_bank2_resv)
    else $error("reserved flag of bank two is set");

  property p_bank3_resv;
    @(posedge hclk) disable iff (!hresetn)
      ({18'h0, pending[77:64]} & ~`PEND_MASK3) == 32'h0;
  endproperty
  a_bank3_resv: assert property (p_bank3_resv)
    else $error("reserved flag of bank three is set");

  // An enabled set write pends interrupt 0 on the next edge.
  property p_set_bank1;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_set && s_q.wr_bank == `PEND_BANK1 &&
       hwdata[0] && irq_enable[0]) |=> pending[0];
  endproperty
  a_set_bank1: assert property (p_set_bank1)
    else $error("set write did not pend an enabled interrupt");

  // A clear through bank three reaches interrupt 66.
  property p_clear_bank3;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && !s_q.wr_set && s_q.wr_bank == `PEND_BANK3 &&
       hwdata[2] && !irq_active[66] && !irq_req[66]) |=> !pending[66];
  endproperty
  a_clear_bank3: assert property (p_clear_bank3)
    else $error("bank three clear did not remove pending flag");

endmodule
